// ===== logic/usart_core.sv
// Purpose: serial transceiver core with baud generator, sync clocking and receive FIFO
// Assumes: rxd already synchronous to pclk, xck_in is synchronised inside; APB slave
// Notes: every output is taken from the single state register

`timescale 1ns/1ps

module usart_core #(
	parameter int DIV_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire usart_pkg::apb_req_t apb_req,
	output usart_pkg::apb_rsp_t apb_rsp,
	input wire logic rxd,
	output logic txd,
	input wire logic xck_in,
	output usart_pkg::xck_drv_t xck_drv,
	output usart_pkg::irq_t irq
);
	import usart_pkg::*;

	typedef struct packed {
		apb_rsp_t rsp;
		logic u2x;
		logic [2:0] irq_en;
		logic rx_en;
		logic tx_en;
		logic csz2;
		logic tx_b8;
		logic [7:0] ctrl_c;
		logic [DIV_W-1:0] divisor;
		logic pwr;
		logic [DIV_W-1:0] baud_cnt;
		xck_drv_t transfer_clock_pin;
		logic [2:0] xs;
		logic [3:0] tx_ps;
		tx_state_t tx_st;
		logic [3:0] tx_idx;
		logic [8:0] tx_sh;
		logic tx_par;
		logic txd;
		logic [8:0] tx_buf;
		logic tx_full;
		logic tx_done;
		rx_state_t rx_st;
		logic [3:0] rx_os;
		logic [1:0] rx_hist;
		logic [3:0] rx_idx;
		logic [8:0] rx_sh;
		logic rx_pbit;
		rx_entry_t held;
		logic held_v;
		logic dor_pend;
		rx_entry_t [1:0] fifo;
		logic rd_ptr;
		logic [1:0] cnt;
		irq_t irq;
	} state_t;

	state_t st;
	state_t nx;
	logic run, sync_m, master, dbl, pol, pen, odd;
	logic [2:0] csz;
	logic [3:0] nbits, ps_last, os_last, os_vote;
	logic [8:0] dmask, rx_data;
	logic access, done, wr, rd, wr_lo, wr_data, miss, pop, push, space;
	logic [31:0] rdata;
	rx_entry_t head, entry, pword;
	logic tick, slv_rise, slv_fall, x_rise, x_fall, chg, smp;
	logic tx_evt, tx_load, tx_end, rx_evt, rx_val, vote, start_det, frame_done;
	logic wr_idx;

	// next-state logic for the whole block
	always_comb begin
		nx = st;
		run = !st.pwr;
		sync_m = st.ctrl_c[B_UMSEL];
		master = sync_m & st.ctrl_c[B_XDIR];
		dbl = st.u2x & !sync_m;
		pol = st.ctrl_c[B_POL];
		pen = st.ctrl_c[B_PEN];
		odd = st.ctrl_c[B_PODD];
		csz = {st.csz2, st.ctrl_c[B_CSZ_LO+1:B_CSZ_LO]};
		nbits = (csz == CSZ_NINE) ? NBITS_NINE : NBITS_BASE + {2'b00, csz[1:0]};
		dmask = 9'h1FF >> (NBITS_NINE - nbits);
		ps_last = dbl ? OS_LAST_DOUBLE : OS_LAST_NORMAL;
		os_last = dbl ? OS_LAST_DOUBLE : OS_LAST_NORMAL;
		os_vote = dbl ? OS_VOTE_DOUBLE : OS_VOTE_NORMAL;
		tick = run && (st.baud_cnt == '0);
		head = (st.cnt != 2'h0) ? st.fifo[st.rd_ptr] : '0;

		// APB: one wait state, effects only at the completing edge
		access = apb_req.psel && apb_req.penable;
		done = access && st.rsp.pready;
		wr = done && apb_req.pwrite;
		rd = done && !apb_req.pwrite;
		wr_lo = wr && (apb_req.paddr == OFS_BAUD_LO);
		wr_data = wr && (apb_req.paddr == OFS_DATA);
		pop = rd && (apb_req.paddr == OFS_DATA) && (st.cnt != 2'h0);
		rdata = '0;
		miss = 1'b0;
		case (apb_req.paddr)
			OFS_DATA: rdata[7:0] = head.data[7:0];
			OFS_CSA: rdata[7:0] = {st.cnt != 2'h0, st.tx_done, !st.tx_full, head.fe,
				head.dor, head.pe, st.u2x, 1'b0};
			OFS_CSB: rdata[7:0] = {st.irq_en, st.rx_en, st.tx_en, st.csz2, head.data[8], st.tx_b8};
			OFS_CSC: rdata[7:0] = st.ctrl_c;
			OFS_BAUD_LO: rdata[7:0] = st.divisor[7:0];
			OFS_BAUD_HI: rdata[DIV_W-9:0] = st.divisor[DIV_W-1:8];
			OFS_POWER: rdata[0] = st.pwr;
			default: miss = 1'b1;
		endcase
		nx.rsp.pready = access && !st.rsp.pready;
		nx.rsp.prdata = (access && !st.rsp.pready && !apb_req.pwrite) ? rdata : 32'h0;
		nx.rsp.pslverr = access && !st.rsp.pready && miss;

		// register writes come first so hardware events below win over clears
		if (wr) begin
			case (apb_req.paddr)
				OFS_DATA: begin
					nx.tx_buf = {(csz == CSZ_NINE) & st.tx_b8, apb_req.pwdata[7:0]};
					nx.tx_full = 1'b1;
				end
				OFS_CSA: begin
					nx.u2x = apb_req.pwdata[B_U2X];
					if (apb_req.pwdata[B_TXC]) begin
						nx.tx_done = 1'b0;
					end
				end
				OFS_CSB: begin
					nx.irq_en = apb_req.pwdata[B_IE_LO+2:B_IE_LO];
					nx.rx_en = apb_req.pwdata[B_RXEN];
					nx.tx_en = apb_req.pwdata[B_TXEN];
					nx.csz2 = apb_req.pwdata[B_CSZ2];
					nx.tx_b8 = apb_req.pwdata[B_TXB8];
				end
				OFS_CSC: nx.ctrl_c = apb_req.pwdata[7:0];
				OFS_BAUD_LO: nx.divisor[7:0] = apb_req.pwdata[7:0];
				OFS_BAUD_HI: nx.divisor[DIV_W-1:8] = apb_req.pwdata[DIV_W-9:0];
				OFS_POWER: nx.pwr = apb_req.pwdata[0];
				default: nx.pwr = st.pwr;
			endcase
		end

		// baud down-counter; reload uses the freshly written divisor
		nx.baud_cnt = (!run || tick || wr_lo) ? nx.divisor : st.baud_cnt - DIV_W'(1);

		// transfer clock: master toggles per baud pulse, slave is synchronised
		nx.xs = {st.xs[1], st.xs[0], xck_in};
		slv_rise = st.xs[1] & !st.xs[2];
		slv_fall = !st.xs[1] & st.xs[2];
		nx.transfer_clock_pin.out = (master && run) ? (st.transfer_clock_pin.out ^ tick) : 1'b0;
		nx.transfer_clock_pin.oe = master;
		x_rise = master ? (tick & !st.transfer_clock_pin.out) : slv_rise;
		x_fall = master ? (tick & st.transfer_clock_pin.out) : slv_fall;
		chg = sync_m && run && (pol ? x_fall : x_rise);
		smp = sync_m && run && (pol ? x_rise : x_fall);

		// transmit prescaler and bit events
		tx_evt = sync_m ? chg : (tick && (st.tx_ps == ps_last));
		if (!run || sync_m) begin
			nx.tx_ps = 4'h0;
		end else if (tick) begin
			nx.tx_ps = (st.tx_ps == ps_last) ? 4'h0 : st.tx_ps + 4'h1;
		end

		// transmitter: state names what is currently on the line
		tx_load = 1'b0;
		tx_end = 1'b0;
		if (!run || !st.tx_en) begin
			nx.tx_st = TX_IDLE;
			nx.txd = 1'b1;
		end else if (tx_evt) begin
			unique case (st.tx_st)
				TX_IDLE: tx_load = st.tx_full;
				TX_START: begin
					nx.txd = st.tx_sh[0];
					nx.tx_sh = st.tx_sh >> 1;
					nx.tx_idx = 4'h1;
					nx.tx_st = TX_DATA;
				end
				TX_DATA: begin
					if (st.tx_idx == nbits) begin
						nx.txd = pen ? st.tx_par : 1'b1;
						nx.tx_st = pen ? TX_PARITY : TX_STOP1;
					end else begin
						nx.txd = st.tx_sh[0];
						nx.tx_sh = st.tx_sh >> 1;
						nx.tx_idx = st.tx_idx + 4'h1;
					end
				end
				TX_PARITY: begin
					nx.txd = 1'b1;
					nx.tx_st = TX_STOP1;
				end
				TX_STOP1: begin
					if (st.ctrl_c[B_STOP2]) begin
						nx.tx_st = TX_STOP2;
					end else begin
						tx_end = 1'b1;
					end
				end
				TX_STOP2: tx_end = 1'b1;
			endcase
			if (tx_end) begin
				if (st.tx_full) begin
					tx_load = 1'b1;
				end else begin
					nx.tx_st = TX_IDLE;
					nx.tx_done = 1'b1;
				end
			end
			if (tx_load) begin
				nx.tx_sh = st.tx_buf & dmask;
				nx.tx_par = ^(st.tx_buf & dmask) ^ odd;
				nx.txd = 1'b0;
				nx.tx_st = TX_START;
				if (!wr_data) begin
					nx.tx_full = 1'b0;
				end
			end
		end

		// receiver sampling: three-sample majority around the bit centre in async mode, a single rxd sample at the clock edge in sync mode
		vote = (st.rx_hist[1] & st.rx_hist[0]) | (st.rx_hist[1] & rxd) |
			(st.rx_hist[0] & rxd);
		rx_evt = sync_m ? smp : (tick && (st.rx_os == os_vote));
		rx_val = sync_m ? rxd : vote;
		if (tick && !sync_m) begin
			nx.rx_hist = {st.rx_hist[0], rxd};
			nx.rx_os = (st.rx_os == os_last) ? 4'h0 : st.rx_os + 4'h1;
		end
		start_det = 1'b0;
		frame_done = 1'b0;
		if (!run || !st.rx_en) begin
			nx.rx_st = RX_IDLE;
		end else begin
			unique case (st.rx_st)
				RX_IDLE: begin
					if (!sync_m && tick && !rxd) begin
						nx.rx_st = RX_START;
						nx.rx_os = 4'h1;
					end else if (sync_m && smp && !rxd) begin
						start_det = 1'b1;
						nx.rx_idx = 4'h0;
						nx.rx_st = RX_DATA;
					end
				end
				RX_START: begin
					if (rx_evt) begin
						start_det = !rx_val;
						nx.rx_idx = 4'h0;
						nx.rx_st = rx_val ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_evt) begin
						nx.rx_sh = {rx_val, st.rx_sh[8:1]};
						nx.rx_idx = st.rx_idx + 4'h1;
						if (st.rx_idx + 4'h1 == nbits) begin
							nx.rx_st = pen ? RX_PARITY : RX_STOP;
						end
					end
				end
				RX_PARITY: begin
					if (rx_evt) begin
						nx.rx_pbit = rx_val;
						nx.rx_st = RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_evt) begin
						frame_done = 1'b1;
						nx.rx_st = RX_IDLE;
					end
				end
			endcase
		end
		rx_data = st.rx_sh >> (NBITS_NINE - nbits);
		entry.data = rx_data;
		entry.fe = !rx_val;
		entry.dor = st.dor_pend;
		entry.pe = pen && (st.rx_pbit != (^rx_data ^ odd));

		// receive FIFO with a separate held entry register as a third level
		space = (st.cnt != 2'h2) || pop;
		push = 1'b0;
		pword = entry;
		if (start_det && st.held_v && !space) begin
			nx.held_v = 1'b0;
			nx.dor_pend = 1'b1;
		end
		if (frame_done) begin
			nx.dor_pend = 1'b0;
			if (space) begin
				push = 1'b1;
			end else begin
				nx.held = entry;
				nx.held_v = 1'b1;
			end
		end else if (st.held_v && space) begin
			push = 1'b1;
			pword = st.held;
			nx.held_v = 1'b0;
		end
		wr_idx = st.rd_ptr ^ st.cnt[0];
		if (push) begin
			nx.fifo[wr_idx] = pword;
		end
		if (pop) begin
			nx.rd_ptr = ~st.rd_ptr;
		end
		nx.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});

		// interrupt request levels
		nx.irq.rx_complete = st.irq_en[2] && (st.cnt != 2'h0);
		nx.irq.tx_complete = st.irq_en[1] && st.tx_done;
		nx.irq.data_empty = st.irq_en[0] && !st.tx_full;
	end

	// single state register; line idles high, frame format at its reset code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.txd <= 1'b1;
			st.ctrl_c <= CSC_RESET;
			st.pwr <= POWER_RESET[0];
		end else begin
			st <= nx;
		end
	end

	assign apb_rsp = st.rsp;
	assign txd = st.txd;
	assign xck_drv = st.transfer_clock_pin;
	assign irq = st.irq;

	// checks kept beside the logic they guard
	a_baud_reload: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && !wr_lo) |=> (st.baud_cnt == st.divisor))
		else $error("baud counter did not reload the divisor");
	a_baud_period: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && st.divisor == DIV_W'(1) && !wr_lo) ##1 (run && !wr_lo) ##1 run |-> tick)
		else $error("baud pulse spacing wrong for divisor one");
	a_xck_async_off: assert property (@(posedge pclk) disable iff (!presetn)
		!st.ctrl_c[B_UMSEL] |=> !xck_drv.oe)
		else $error("transfer clock driven outside synchronous mode");
	a_slave_latency: assert property (@(posedge pclk) disable iff (!presetn)
		(sync_m && !master && slv_rise) |-> ($past(xck_in, 2) && !$past(xck_in, 3)))
		else $error("slave clock edge not two cycles late");
	a_tx_div_normal: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_evt && !sync_m && !st.u2x && run && st.divisor == '0) |=> !tx_evt [*8])
		else $error("transmit event too soon in normal mode");
	a_fifo_pop: assert property (@(posedge pclk) disable iff (!presetn)
		(pop && !push) |=> (st.cnt == $past(st.cnt) - 2'h1))
		else $error("data read did not pop the FIFO");
	a_overrun_mark: assert property (@(posedge pclk) disable iff (!presetn)
		(start_det && st.held_v && !space) |=> (st.dor_pend && !st.held_v))
		else $error("overrun not marked on start with full buffers");
	a_tx_parity: assert property (@(posedge pclk) disable iff (!presetn)
		(st.tx_st == TX_PARITY) |-> (txd == st.tx_par))
		else $error("parity bit not on the line");
	a_tx_line_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(st.tx_st == TX_IDLE) |-> txd)
		else $error("line not high while transmitter idle");
	a_tx_buffered: assert property (@(posedge pclk) disable iff (!presetn)
		wr_data |=> st.tx_full)
		else $error("data write did not fill the transmit buffer");

endmodule

// ===== logic/usart_pkg.sv
// Purpose: shared constants and carrier types for the serial transceiver core
// Assumes: 32-bit APB register bus, one register per aligned word
// Notes: all register offsets are byte addresses

package usart_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_CSA = 8'h04;
	localparam logic [7:0] OFS_CSB = 8'h08;
	localparam logic [7:0] OFS_CSC = 8'h0C;
	localparam logic [7:0] OFS_BAUD_LO = 8'h10;
	localparam logic [7:0] OFS_BAUD_HI = 8'h14;
	localparam logic [7:0] OFS_POWER = 8'h18;

	// serial_ctrl_status_a fields
	localparam int B_RXC = 7;
	localparam int B_TXC = 6;
	localparam int B_UDRE = 5;
	localparam int B_FE = 4;
	localparam int B_DOR = 3;
	localparam int B_PE = 2;
	localparam int B_U2X = 1;
	// control b fields
	localparam int B_IE_LO = 5;
	localparam int B_RXEN = 4;
	localparam int B_TXEN = 3;
	localparam int B_CSZ2 = 2;
	localparam int B_RXB8 = 1;
	localparam int B_TXB8 = 0;
	// serial_ctrl_status_c fields
	localparam int B_XDIR = 7;
	localparam int B_UMSEL = 6;
	localparam int B_PEN = 5;
	localparam int B_PODD = 4;
	localparam int B_STOP2 = 3;
	localparam int B_CSZ_LO = 1;
	localparam int B_POL = 0;

	// reset values
	localparam logic [7:0] CSC_RESET = 8'h06;
	localparam logic [7:0] POWER_RESET = 8'h00;

	// frame and oversampling counts
	localparam logic [2:0] CSZ_NINE = 3'h7;
	localparam logic [3:0] NBITS_BASE = 4'h5;
	localparam logic [3:0] NBITS_NINE = 4'h9;
	localparam logic [3:0] OS_LAST_NORMAL = 4'hF;
	localparam logic [3:0] OS_LAST_DOUBLE = 4'h7;
	localparam logic [3:0] OS_VOTE_NORMAL = 4'h9;
	localparam logic [3:0] OS_VOTE_DOUBLE = 4'h5;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic out;
		logic oe;
	} xck_drv_t;

	typedef struct packed {
		logic rx_complete;
		logic tx_complete;
		logic data_empty;
	} irq_t;

	typedef struct packed {
		logic [8:0] data;
		logic fe;
		logic dor;
		logic pe;
	} rx_entry_t;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2} tx_state_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

endpackage

// ===== tb/serial_peer.sv
// Purpose: remote serial device facing the transceiver's rxd and txd lines
// Assumes: bit period or clock half period given in pclk cycles by the caller
// Notes: rxd idles high between frames; xck rests at its idle level outside frames
`timescale 1ns/1ps
module serial_peer (
	input wire logic pclk,
	input wire logic txd,
	output logic rxd,
	output logic transfer_clock_pin
);
	int cyc = 0;
	int misses = 0;
	initial rxd = 1'b1;
	initial transfer_clock_pin = 1'b0;
	// free running cycle count, used to time frame starts
	always @(posedge pclk) begin
		cyc <= cyc + 1;
	end
	// one frame on rxd: start, data lsb first, optional parity, stop, then idle
	task automatic send(input logic [8:0] d, input int nb, input bit pen, input logic pb,
		input logic sv, input int bp);
		logic q[$];
		q.push_back(1'b0);
		for (int i = 0; i < nb; i++) q.push_back(d[i]);
		if (pen) q.push_back(pb);
		q.push_back(sv);
		q.push_back(1'b1);
		foreach (q[i]) begin
			@(posedge pclk);
			rxd <= q[i];
			repeat (bp - 1) @(posedge pclk);
		end
	endtask
	// short low glitch, too brief to pass the start bit vote
	task automatic pulse(input int n);
		@(posedge pclk);
		rxd <= 1'b0;
		repeat (n) @(posedge pclk);
		rxd <= 1'b1;
	endtask
	// catch one frame from txd, sampling each bit in its middle; bounded wait for start
	task automatic get(input int nb, input bit pen, input int bp, output logic [8:0] d,
		output logic p, output logic s, output int t0);
		int n;
		n = 0;
		d = '0;
		while (txd !== 1'b0 && n < 30000) begin
			@(posedge pclk);
			n++;
		end
		if (txd !== 1'b0) misses++; // no start bit within the bound counts as a mismatch
		t0 = cyc;
		repeat (bp / 2) @(posedge pclk);
		for (int i = 0; i < nb; i++) begin
			repeat (bp) @(posedge pclk);
			d[i] = txd;
		end
		p = 1'b0;
		if (pen) begin
			repeat (bp) @(posedge pclk);
			p = txd;
		end
		repeat (bp) @(posedge pclk);
		s = txd;
	endtask
	// synchronous slave frame: leading clock edge changes rxd, trailing edge samples txd
	task automatic sync_xfer(input bit pol, input logic [7:0] dout, input int hp,
		output logic [9:0] g);
		logic [9:0] q;
		q = {1'b1, dout, 1'b0};
		g = '0;
		@(posedge pclk);
		transfer_clock_pin <= pol;
		repeat (4) @(posedge pclk);
		for (int i = 0; i < 12; i++) begin
			transfer_clock_pin <= !pol;
			rxd <= (i < 10) ? q[i] : 1'b1;
			repeat (hp) @(posedge pclk);
			if (i < 10) g[i] = txd;
			transfer_clock_pin <= pol;
			repeat (hp) @(posedge pclk);
		end
	endtask
endmodule

// ===== tb/usart_clock_and_buffering_bench.sv
// Purpose: self-checking bench for the serial transceiver core
// Assumes: divisor kept at 3 or less so frames stay short
// Notes: random formats and data from a fixed seed, corner cases written by hand
`timescale 1ns/1ps
module usart_clock_and_buffering_bench;
	import usart_pkg::*;
	logic pclk;
	logic presetn;
	apb_req_t req;
	apb_rsp_t rsp;
	logic rxd;
	logic txd;
	logic transfer_clock_pin;
	xck_drv_t xd;
	irq_t irq;
	int err_total = 0;
	int check_count = 0;
	int seed = 32'h06175747;
	logic [31:0] rv;
	logic er;

	usart_core dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.rxd(rxd), .txd(txd), .xck_in(transfer_clock_pin), .xck_drv(xd), .irq(irq));
	serial_peer peer_u (.pclk(pclk), .txd(txd), .rxd(rxd), .transfer_clock_pin(transfer_clock_pin));

	task automatic end_of_test();
		err_total += peer_u.misses;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one transfer, request held until pready is seen high; idle cycle after
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 100);
		if (rsp.pready !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		rv = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		apb(1'b0, a, '0);
		chk(nm, e, rv & m);
	endtask
	function automatic logic parf(input logic [8:0] d, input int nb, input bit odd);
		logic p;
		p = odd;
		for (int i = 0; i < nb; i++) p = p ^ d[i];
		return p;
	endfunction
	// poll until the write buffer has moved on, bounded
	task automatic wait_empty();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFS_CSA, '0);
			n++;
		end while (rv[B_UDRE] !== 1'b1 && n < 200);
		chk("data empty", 32'h1, 32'(rv[B_UDRE]));
	endtask
	// two characters back to back with random divisor, speed and format
	task automatic tx_run(input int nb);
		logic [31:0] r;
		logic [8:0] d1, d2, g, m;
		logic [2:0] cs;
		logic p, s;
		int dv, bp, t1, t2;
		bit ds, pen, odd, st2;
		r = $random(seed);
		dv = int'(r[1:0]);
		{ds, pen, odd, st2} = r[5:2];
		d1 = r[14:6];
		d2 = r[23:15];
		m = 9'((1 << nb) - 1);
		cs = (nb == 9) ? 3'h7 : 3'(nb - 5);
		bp = (dv + 1) * (ds ? 8 : 16);
		// halt while the rate changes, so no bit event straddles old and new settings
		apb(1'b1, OFS_POWER, 32'h1);
		apb(1'b1, OFS_BAUD_LO, 32'(dv));
		apb(1'b1, OFS_CSA, {30'h0, ds, 1'b0});
		apb(1'b1, OFS_CSC, {26'h0, pen, odd, st2, cs[1:0], 1'b0});
		apb(1'b1, OFS_CSB, {24'h0, 5'h1F, cs[2], 1'b0, d1[8]});
		apb(1'b1, OFS_POWER, 32'h0);
		fork
			peer_u.get(nb, pen, bp, g, p, s, t1);
			begin
				apb(1'b1, OFS_DATA, {24'h0, d1[7:0]});
				wait_empty();
				apb(1'b1, OFS_CSB, {24'h0, 5'h1F, cs[2], 1'b0, d2[8]});
				apb(1'b1, OFS_DATA, {24'h0, d2[7:0]});
			end
		join
		chk("tx data", 32'(d1 & m), 32'(g));
		if (pen) chk("tx parity", 32'(parf(d1, nb, odd)), 32'(p));
		chk("tx stop", 32'h1, 32'(s));
		peer_u.get(nb, pen, bp, g, p, s, t2);
		chk("tx data 2", 32'(d2 & m), 32'(g));
		chk("tx frame length", 32'(bp * (2 + nb + pen + st2)), 32'(t2 - t1));
		repeat (2 * bp + 4) @(posedge pclk);
		chk("tx irqs", 32'h3, 32'(irq));
	endtask
	// n frames in: two in the fifo, one held, a fourth drops the held one
	task automatic rx_run(input int n);
		logic [7:0] b[4];
		logic [31:0] r;
		for (int i = 0; i < n; i++) begin
			r = $random(seed);
			b[i] = r[7:0];
			peer_u.send({1'b0, b[i]}, 8, 1'b0, 1'b0, 1'b1, 16);
		end
		chk("rx irq", 32'h1, 32'(irq.rx_complete));
		for (int j = 0; j < 3; j++) begin
			rd("rx status", OFS_CSA, 32'h88, {24'h0, 4'h8, j == 2 && n == 4, 3'h0});
			rd("rx data", OFS_DATA, 32'hFF, 32'(j == 2 ? b[n - 1] : b[j]));
		end
		rd("rx empty", OFS_CSA, 32'h80, 32'h0);
	endtask

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		end_of_test();
	end
	// main sequence
	initial begin
		logic [8:0] g;
		logic p;
		logic s;
		int t;
		int lv;
		int n;
		logic [7:0] b8;
		logic [9:0] fr;
		presetn = 1'b0;
		req = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("idle pins", 32'h2, {30'h0, txd, xd.oe});
		rd("csc reset", OFS_CSC, 32'hFF, 32'(CSC_RESET));
		rd("baud reset", OFS_BAUD_LO, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, 8'h1C, '0);
		chk("unmapped", 32'h1, 32'(er));
		apb(1'b1, OFS_BAUD_HI, 32'hFF);
		rd("baud high", OFS_BAUD_HI, 32'hFFFFFFFF, 32'hF);
		apb(1'b1, OFS_BAUD_HI, 32'h0);
		apb(1'b1, OFS_POWER, 32'h0);
		for (int k = 0; k < 10; k++) tx_run(5 + k % 5);
		apb(1'b1, OFS_CSA, 32'h0);
		apb(1'b1, OFS_BAUD_LO, 32'h0);
		apb(1'b1, OFS_CSC, 32'h06);
		apb(1'b1, OFS_CSB, 32'hF8);
		rx_run(3);
		rx_run(4);
		peer_u.pulse(4);
		repeat (40) @(posedge pclk);
		rd("false start", OFS_CSA, 32'h80, 32'h0);
		apb(1'b1, OFS_CSC, 32'h36);
		peer_u.send(9'h0A5, 8, 1'b1, parf(9'h0A5, 8, 1'b1), 1'b1, 16);
		peer_u.send(9'h03C, 8, 1'b1, ~parf(9'h03C, 8, 1'b1), 1'b0, 16);
		rd("good flags", OFS_CSA, 32'h14, 32'h0);
		rd("good data", OFS_DATA, 32'hFF, 32'hA5);
		rd("bad flags", OFS_CSA, 32'h14, 32'h14);
		rd("bad data", OFS_DATA, 32'hFF, 32'h3C);
		// synchronous master: double speed kept clear, clock half period is divisor plus one
		apb(1'b1, OFS_CSA, 32'h0);
		apb(1'b1, OFS_BAUD_LO, 32'h2);
		apb(1'b1, OFS_CSC, 32'hC6);
		@(posedge pclk); // enable follows the mode bits by one cycle
		chk("master oe", 32'h1, 32'(xd.oe));
		for (int h = 0; h < 2; h++) begin
			lv = int'(xd.out);
			n = 0;
			while (int'(xd.out) == lv && n < 50) begin
				@(posedge pclk);
				n++;
			end
		end
		chk("xck half period", 32'h3, 32'(n));
		apb(1'b1, OFS_CSC, 32'h46);
		@(posedge pclk);
		chk("slave oe", 32'h0, 32'(xd.oe));
		apb(1'b1, OFS_CSC, 32'h06);
		apb(1'b1, OFS_BAUD_LO, 32'h0);
		chk("async xck", 32'h0, 32'(xd));
		// halted block must not start a frame until the power bit clears
		apb(1'b1, OFS_POWER, 32'h1);
		apb(1'b1, OFS_DATA, 32'h5A);
		lv = 0;
		repeat (100) begin
			@(posedge pclk);
			if (txd !== 1'b1) lv = 1;
		end
		chk("halted txd", 32'h0, 32'(lv));
		fork
			peer_u.get(8, 1'b0, 16, g, p, s, t);
			apb(1'b1, OFS_POWER, 32'h0);
		join
		chk("resumed data", 32'h5A, 32'(g));
		// synchronous slave, both polarities; peer clock period is sixteen pclk cycles
		repeat (20) @(posedge pclk);
		for (int c = 0; c < 2; c++) begin
			b8 = 8'($random(seed));
			apb(1'b1, OFS_CSC, 32'h46 | c);
			apb(1'b1, OFS_DATA, {24'h0, ~b8});
			peer_u.sync_xfer(c[0], b8, 8, fr);
			chk("sync tx frame", {22'h0, 1'b1, ~b8, 1'b0}, 32'(fr));
			rd("sync rx data", OFS_DATA, 32'hFF, 32'(b8));
		end
		end_of_test();
	end
endmodule
